/* verification/bfbt_far_model.sv */
// Purpose: far side model of monitored stages and breaker contacts
// Assumes: commands change at the falling edge of ref_clk
// Notes:   slow mode stretches stage release to mimic stage reset time
`default_nettype none
module bfbt_far_model (
  input  wire logic       ref_clk,
  input  wire logic [3:0] fault_cmd,
  input  wire logic [3:0] open_cmd,
  input  wire logic       slow,
  output logic [3:0]      stage_started,
  output logic [3:0]      cb_open
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] lag1_q   = 4'h0;
  logic [3:0] lag2_q   = 4'h0;
  logic [3:0] st_cap_q = 4'h0;
  logic [3:0] cb_cap_q = 4'h0;
  logic [3:0] st_q     = 4'h0;
  logic [3:0] cb_q     = 4'h0;
  // commands taken on the rising edge, where they are stable
  // stages drop late when slow, so release never beats the fault
  always @(posedge ref_clk)
  begin
    lag1_q   <= fault_cmd;
    lag2_q   <= lag1_q;
    st_cap_q <= slow ? (fault_cmd | lag1_q | lag2_q) : fault_cmd;
    cb_cap_q <= open_cmd;
  end
  // pins move on the falling edge, away from the sampling edge
  always @(negedge ref_clk)
  begin
    st_q <= st_cap_q;
    cb_q <= cb_cap_q;
  end
  assign stage_started = st_q;
  assign cb_open       = cb_q;
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: self-checking bench for the breaker failure backup trip block
// Assumes: inputs move at the falling edge, reset held 12 cycles
// Notes:   prescale cut to 4 cycles per ms so trip timing fits the run
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b1;
  logic blk = 1'b0;
  logic slow = 1'b0;
  logic [3:0] stg_en = 4'hF;
  logic [3:0] fault = 4'h0;
  logic [3:0] opn = 4'h0;
  logic [3:0] started;
  logic [3:0] cb;
  bfbt_pkg::bfbt_cond_cfg_s [3:0] cfg = '0;
  logic [2:0][15:0] ph = '0;
  logic [15:0] gnd = 16'h0000;
  bfbt_pkg::bfbt_evt_s ev_en = 4'hF;
  bfbt_pkg::bfbt_evt_s ev;
  bfbt_pkg::bfbt_evt_s seen = 4'h0;
  logic start, retrip, trip, pz, gz;
  int mismatches = 0;
  int comparisons = 0;
  initial forever #12.5 ref_clk = ~ref_clk;
  // sticky capture, events are single-cycle pulses
  always @(posedge ref_clk) seen <= seen | ev;
  bfbt_far_model i_far (.ref_clk(ref_clk), .fault_cmd(fault), .open_cmd(opn),
    .slow(slow), .stage_started(started), .cb_open(cb));
  // delays of 40 and 200 ms leave room for breaker and stage reset
  // short prescale: 1 ms is 4 cycles, so 40 ms is 160 cycles
  bfbt_top #(.TICKS_PER_MS(4)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .backup_function_enable(en),
    .cond_cfg(cfg), .stage_enabled(stg_en), .stage_started(started), .cb_open(cb),
    .stage_block(blk), .phase_cur(ph), .ground_cur(gnd), .phase_zero_thr(16'h0100),
    .ground_zero_thr(16'h0040), .retrip_delay_ms(8'h28), .backup_delay_ms(8'hC8),
    .event_enable(ev_en), .start_out(start), .retrip_out(retrip),
    .backup_trip_out(trip), .phase_zero_out(pz), .ground_zero_out(gz), .event_out(ev));
  task automatic cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_evt(input bfbt_pkg::bfbt_evt_s got, input bfbt_pkg::bfbt_evt_s exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one start then release on a selector with no reset criterion
  task automatic t_start();
    cfg[0] = 4'h8;
    seen = 4'h0;
    fault = 4'h1;
    tick(4);
    cmp1(start, 1'b0);
    tick(1);
    cmp1(start, 1'b1);
    fault = 4'h0;
    tick(6);
    cmp1(start, 1'b0);
    cmp_evt(seen, 4'hC);
  endtask
  // stage disabled or function disabled gives no start
  task automatic t_refuse();
    stg_en = 4'hE;
    fault = 4'h1;
    tick(8);
    cmp1(start, 1'b0);
    stg_en = 4'hF;
    en = 1'b0;
    tick(8);
    cmp1(start, 1'b0);
    fault = 4'h0;
    tick(6);
    en = 1'b1; // stage already quiet, so re-enable gives no start
    tick(4);
  endtask
  // block hides outputs, release brings start back
  task automatic t_block();
    fault = 4'h1;
    tick(6);
    blk = 1'b1;
    tick(4);
    cmp1(start, 1'b0);
    cmp1(trip, 1'b0);
    blk = 1'b0;
    tick(4);
    cmp1(start, 1'b1);
    fault = 4'h0;
    tick(6);
  endtask
  // breaker status AND stage reset, start_off event masked
  task automatic t_and();
    cfg[0] = 4'hE;
    slow = 1'b1;
    ev_en = 4'h8;
    fault = 4'h1;
    tick(6);
    seen = 4'h0;
    fault = 4'h0;
    tick(10);
    cmp1(start, 1'b1);
    opn = 4'h1;
    tick(6);
    cmp1(start, 1'b0);
    cmp_evt(seen, 4'h0);
    opn = 4'h0;
    slow = 1'b0;
    ev_en = 4'hF;
    cfg[0] = 4'h0;
  endtask
  // zero-current detectors and selector reset by zero current
  task automatic t_zero();
    ph = {16'h0080, 16'h0200, 16'h0080};
    gnd = 16'h0010;
    tick(3);
    cmp1(pz, 1'b0);
    cmp1(gz, 1'b1);
    cfg[0] = 4'h9;
    fault = 4'h1;
    tick(6);
    fault = 4'h0;
    tick(8);
    cmp1(start, 1'b1);
    ph[1] = 16'h0080;
    gnd = 16'h0050;
    tick(6);
    cmp1(pz, 1'b1);
    cmp1(gz, 1'b0);
    cmp1(start, 1'b0);
    cfg[0] = 4'h0;
  endtask
  // contact selector ignores breaker and current criteria
  task automatic t_sel4();
    cfg[3] = 4'hD;
    ph = '1;
    fault = 4'h8;
    tick(6);
    cmp1(start, 1'b1);
    fault = 4'h0;
    tick(6);
    cmp1(start, 1'b0);
    cmp1(retrip, 1'b0);
  endtask
  // both timing stages, block freezes the timer, release clears it
  task automatic t_trip();
    cfg[3] = 4'h0;
    cfg[0] = 4'h8;
    seen = 4'h0;
    fault = 4'h1;
    tick(163);
    cmp1(retrip, 1'b0);
    tick(1);
    cmp1(retrip, 1'b1);
    cmp1(trip, 1'b0);
    tick(36);
    blk = 1'b1;
    tick(4);
    cmp1(retrip, 1'b0);
    tick(16);
    blk = 1'b0;
    tick(4);
    cmp1(retrip, 1'b1);
    tick(599);
    cmp1(trip, 1'b0);
    tick(1);
    cmp1(trip, 1'b1);
    fault = 4'h0;
    tick(6);
    cmp1(trip, 1'b0);
    cmp_evt(seen, 4'hF);
    fault = 4'h1;
    tick(163);
    cmp1(retrip, 1'b0);
    tick(1);
    cmp1(retrip, 1'b1);
    fault = 4'h0;
    tick(6);
    cmp1(start, 1'b0);
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // whole sequence is about 1130 cycles, limit is far above it
  initial
  begin
    #(25 * 5000);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    tick(2);
    t_start();
    t_refuse();
    t_block();
    t_and();
    t_zero();
    t_sel4();
    t_trip();
    end_of_test();
  end
endmodule
`default_nettype wire

/* verilog/bfbt_pkg.sv */
// Purpose: shared constants and carriers for the breaker failure backup trip block
// Assumes: 40 MHz ref_clk, millisecond timer ticks derived from it
// Notes:   current comparisons use unsigned magnitudes in a common scale
`default_nettype none
package bfbt_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned DELAY_MIN_MS  = 40;
  localparam int unsigned DELAY_MAX_MS  = 200;
  localparam int unsigned TOL_MS        = 20;
  localparam int unsigned NUM_COND      = 4;
  localparam int unsigned DLY_W         = 8;
  localparam int unsigned TICK_W        = 16;
  localparam int unsigned CUR_W         = 16;
  localparam int unsigned ZC_COND_LAST  = 1;  // selectors 0..1 may use zero current
  localparam int unsigned MON_COND      = 3;  // selector that watches contacts and inputs
  localparam logic [DLY_W-1:0]  DLY_ZERO  = 8'h00;
  localparam logic [TICK_W-1:0] TICK_ZERO = 16'h0000;

  // one condition selector setting
  typedef struct packed {
    logic use_start;      // selector participates
    logic rst_cb;         // reset by breaker status
    logic rst_stage;      // reset by monitored stage release
    logic rst_zero;       // reset by zero current
  } bfbt_cond_cfg_s;

  // event pulses toward the event log
  typedef struct packed {
    logic start_on;
    logic start_off;
    logic trip_on;
    logic trip_off;
  } bfbt_evt_s;
endpackage
`default_nettype wire

/* verilog/bfbt_top.sv */
// Purpose: second breaker failure stage with re-trip and backup trip timers
// Assumes: stage, breaker and contact inputs are asynchronous pins; settings are static
// Notes:   delays in ms, re-trip and backup trip share start and reset logic
`default_nettype none
module bfbt_top #(
  parameter int unsigned NCOND        = bfbt_pkg::NUM_COND,
  parameter int unsigned TICKS_PER_MS = bfbt_pkg::CYC_PER_MS
) (
  input  wire logic                               ref_clk,
  input  wire logic                               reset_n,
  input  wire logic                               backup_function_enable,
  input  wire bfbt_pkg::bfbt_cond_cfg_s [NCOND-1:0] cond_cfg,
  input  wire logic [NCOND-1:0]                   stage_enabled,
  input  wire logic [NCOND-1:0]                   stage_started,
  input  wire logic [NCOND-1:0]                   cb_open,
  input  wire logic                               stage_block,
  input  wire logic [2:0][bfbt_pkg::CUR_W-1:0]    phase_cur,
  input  wire logic [bfbt_pkg::CUR_W-1:0]         ground_cur,
  input  wire logic [bfbt_pkg::CUR_W-1:0]         phase_zero_thr,
  input  wire logic [bfbt_pkg::CUR_W-1:0]         ground_zero_thr,
  input  wire logic [bfbt_pkg::DLY_W-1:0]         retrip_delay_ms,
  input  wire logic [bfbt_pkg::DLY_W-1:0]         backup_delay_ms,
  input  wire bfbt_pkg::bfbt_evt_s                event_enable,
  output logic                                    start_out,
  output logic                                    retrip_out,
  output logic                                    backup_trip_out,
  output logic                                    phase_zero_out,
  output logic                                    ground_zero_out,
  output bfbt_pkg::bfbt_evt_s                     event_out
);

  // clamp a delay setting into the supported range
  function automatic logic [bfbt_pkg::DLY_W-1:0] clamp_ms(input logic [bfbt_pkg::DLY_W-1:0] v);
    logic [bfbt_pkg::DLY_W-1:0] lo;
    logic [bfbt_pkg::DLY_W-1:0] hi;
    lo = bfbt_pkg::DLY_W'(bfbt_pkg::DELAY_MIN_MS);
    hi = bfbt_pkg::DLY_W'(bfbt_pkg::DELAY_MAX_MS);
    clamp_ms = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  localparam logic [bfbt_pkg::TICK_W-1:0] TICK_LAST =
    bfbt_pkg::TICK_W'(TICKS_PER_MS - 1);

  // two-flop synchronisers for pin inputs
  logic [NCOND-1:0] en_m_q, en_s_q, st_m_q, st_s_q, cb_m_q, cb_s_q;
  logic             blk_m_q, blk_s_q, fen_m_q, fen_s_q;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_m_q <= '0; en_s_q <= '0; st_m_q <= '0; st_s_q <= '0;
      cb_m_q <= '0; cb_s_q <= '0;
      blk_m_q <= 1'b0; blk_s_q <= 1'b0; fen_m_q <= 1'b0; fen_s_q <= 1'b0;
    end
    else
    begin
      en_m_q <= stage_enabled; en_s_q <= en_m_q;
      st_m_q <= stage_started; st_s_q <= st_m_q;
      cb_m_q <= cb_open;       cb_s_q <= cb_m_q;
      blk_m_q <= stage_block;  blk_s_q <= blk_m_q;
      fen_m_q <= backup_function_enable; fen_s_q <= fen_m_q;
    end
  end

  // zero current detectors, independent of stage state
  // separate phase/ground
  wire phase_zero_d;
  wire ground_zero_d;
  assign phase_zero_d  = (phase_cur[0] < phase_zero_thr) && (phase_cur[1] < phase_zero_thr)
                      && (phase_cur[2] < phase_zero_thr);
  assign ground_zero_d = ground_cur < ground_zero_thr;

  // per selector start and reset terms
  wire [NCOND-1:0] cond_start;  // nets: each bit has its own assign
  wire [NCOND-1:0] cond_reset;

  generate
    for (genvar i = 0; i < NCOND; i++)
    begin : g_cond
      wire sel_rst_cb, sel_rst_stage, sel_rst_zero, any_sel, zc_level;
      // zero current only selectors 0 and 1
      assign sel_rst_zero  = (i <= bfbt_pkg::ZC_COND_LAST) && cond_cfg[i].rst_zero;
      // contact selector resets only on drop
      assign sel_rst_cb    = (i != bfbt_pkg::MON_COND) && cond_cfg[i].rst_cb;
      assign any_sel       = sel_rst_cb | cond_cfg[i].rst_stage | sel_rst_zero;
      assign sel_rst_stage = (i == bfbt_pkg::MON_COND) || cond_cfg[i].rst_stage || !any_sel;
      // second selector watches ground stages
      assign zc_level      = (i == 1) ? ground_zero_d : phase_zero_d;
      assign cond_start[i] = cond_cfg[i].use_start && en_s_q[i] && st_s_q[i];
      assign cond_reset[i] = !cond_cfg[i].use_start ||
                             ((!sel_rst_cb || cb_s_q[i]) &&
                              (!sel_rst_stage || !st_s_q[i]) &&
                              (!sel_rst_zero || zc_level));
    end
  endgenerate

  wire any_start;
  wire all_reset;
  assign any_start = |cond_start;
  assign all_reset = &cond_reset;

  // running state: set by start, held until reset criteria and start gone
  logic active_q;
  wire  active_d;
  assign active_d = fen_s_q && (any_start || (active_q && !all_reset));

  // millisecond prescaler and elapsed count, frozen while blocked
  logic [bfbt_pkg::TICK_W-1:0] tick_q;
  logic [bfbt_pkg::DLY_W-1:0]  ms_q;
  wire                         ms_tick;
  wire                         ms_sat;
  assign ms_tick = (tick_q == TICK_LAST);
  assign ms_sat  = (ms_q == bfbt_pkg::DLY_W'(bfbt_pkg::DELAY_MAX_MS));

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_q <= 1'b0;
      tick_q   <= bfbt_pkg::TICK_ZERO;
      ms_q     <= bfbt_pkg::DLY_ZERO;
    end
    else
    begin
      active_q <= active_d;
      if (!active_d)
      begin
        tick_q <= bfbt_pkg::TICK_ZERO;
        ms_q   <= bfbt_pkg::DLY_ZERO;
      end
      else if (!blk_s_q)
      begin
        tick_q <= ms_tick ? bfbt_pkg::TICK_ZERO : tick_q + 1'b1;
        if (ms_tick && !ms_sat)
          ms_q <= ms_q + 1'b1;
      end
    end
  end

  // two timing stages off one timer
  // clamp delay range
  wire retrip_hit;
  wire backup_hit;
  assign retrip_hit = ms_q >= clamp_ms(retrip_delay_ms);
  assign backup_hit = ms_q >= clamp_ms(backup_delay_ms);

  wire start_d, retrip_d, backup_d;
  assign start_d  = active_q && !blk_s_q;
  assign retrip_d = start_d && retrip_hit;
  assign backup_d = start_d && backup_hit;

  wire bfbt_pkg::bfbt_evt_s evt_d;
  assign evt_d.start_on  = event_enable.start_on  && start_d && !start_out;
  assign evt_d.start_off = event_enable.start_off && !start_d && start_out;
  assign evt_d.trip_on   = event_enable.trip_on   && backup_d && !backup_trip_out;
  assign evt_d.trip_off  = event_enable.trip_off  && !backup_d && backup_trip_out;

  // registered outputs
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      start_out       <= 1'b0;
      retrip_out      <= 1'b0;
      backup_trip_out <= 1'b0;
      phase_zero_out  <= 1'b0;
      ground_zero_out <= 1'b0;
      event_out       <= '0;
    end
    else
    begin
      start_out       <= start_d;
      retrip_out      <= retrip_d;
      backup_trip_out <= backup_d;
      phase_zero_out  <= phase_zero_d;
      ground_zero_out <= ground_zero_d;
      event_out       <= evt_d;
    end
  end

  chk_block_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(blk_s_q) |-> !start_out && !retrip_out && !backup_trip_out)
    else $error("output active while blocked");

  chk_timer_freeze: assert property (@(posedge ref_clk) disable iff (!reset_n)
    blk_s_q && active_d |=> ms_q == $past(ms_q))
    else $error("timer moved while blocked");

  chk_enable_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fen_s_q |=> !active_q ##1 !start_out)
    else $error("active while disabled");

  chk_timer_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !active_q |-> ms_q == bfbt_pkg::DLY_ZERO)
    else $error("timer not cleared");

  chk_trip_expiry: assert property (@(posedge ref_clk) disable iff (!reset_n)
    backup_trip_out |-> $past(ms_q) >= bfbt_pkg::DLY_W'(bfbt_pkg::DELAY_MIN_MS))
    else $error("trip before minimum delay");

  chk_start_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fen_s_q && any_start && !blk_s_q ##1 !blk_s_q |=> start_out)
    else $error("start missing");

  chk_event_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !$past(event_enable.trip_on) |-> !event_out.trip_on)
    else $error("trip event while disabled");

  // zero current needs all phases low
  chk_zero_all: assert property (@(posedge ref_clk) disable iff (!reset_n)
    phase_zero_out |-> $past(phase_cur[0] < phase_zero_thr && phase_cur[1] < phase_zero_thr
                              && phase_cur[2] < phase_zero_thr))
    else $error("zero current with high phase");

  chk_trip_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
    retrip_out |-> $past(ms_q >= clamp_ms(retrip_delay_ms)))
    else $error("re-trip before its delay");

  // every event kind masked by its own enable
  chk_event_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (event_out & ~$past(event_enable)) == 4'h0)
    else $error("event while its enable is off");

  chk_timer_resume: assert property (@(posedge ref_clk) disable iff (!reset_n)
    active_d && !blk_s_q && ms_tick && !ms_sat |=> ms_q == $past(ms_q) + 1'b1)
    else $error("timer did not advance");

  // release clears running state and timer
  chk_release_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !any_start && all_reset |=> !active_q && ms_q == bfbt_pkg::DLY_ZERO)
    else $error("release did not clear");

  // a start needs an enabled and started stage
  chk_stage_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    any_start |-> (en_s_q & st_s_q) != '0)
    else $error("start without enabled started stage");

  // contact selector releases when its signals drop
  chk_contact_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !st_s_q[bfbt_pkg::MON_COND] |-> cond_reset[bfbt_pkg::MON_COND])
    else $error("contact selector held after drop");

  // ground detector follows its own threshold
  chk_zero_ground: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ground_zero_out |-> $past(ground_cur < ground_zero_thr))
    else $error("ground zero with high current");

  chk_enable_trip: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fen_s_q |=> ##1 (!retrip_out && !backup_trip_out))
    else $error("trip while disabled");

  // trip event comes with the rising backup trip
  chk_trip_event: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(backup_trip_out) |-> event_out.trip_on == $past(event_enable.trip_on))
    else $error("trip event missing at expiry");

endmodule
`default_nettype wire
